// ===== inc/sysref_pkg.sv
// constants, field layouts and types of the sysref capture control block
// assumes a single 200 MHz clock and an axi4-lite register bus
package sysref_pkg;

    // ---------------------------------------------------------------
    // register indices and byte addresses (byte address = 4 * index)
    // ---------------------------------------------------------------
    localparam logic [11:0] IDX_CFG   = 12'h0120;
    localparam logic [11:0] IDX_IGN   = 12'h0121;
    localparam logic [11:0] IDX_WIN   = 12'h0122;
    localparam logic [11:0] IDX_STAT  = 12'h012A;
    localparam logic [15:0] ADDR_CFG  = {2'b00, IDX_CFG, 2'b00};
    localparam logic [15:0] ADDR_IGN  = {2'b00, IDX_IGN, 2'b00};
    localparam logic [15:0] ADDR_WIN  = {2'b00, IDX_WIN, 2'b00};
    localparam logic [15:0] ADDR_STAT = {2'b00, IDX_STAT, 2'b00};

    // ---------------------------------------------------------------
    // reset values, writable masks and field positions
    // ---------------------------------------------------------------
    localparam logic [7:0] CFG_RST   = 8'h00;
    localparam logic [7:0] IGN_RST   = 8'h00;
    localparam logic [7:0] WIN_RST   = 8'h00;
    localparam logic [7:0] CFG_WMASK = 8'h5E;
    localparam logic [7:0] IGN_WMASK = 8'h0F;
    localparam logic [7:0] WIN_WMASK = 8'h0F;
    localparam int CFG_FLAG_RST = 6;
    localparam int CFG_TRANS    = 4;
    localparam int CFG_EDGE     = 3;
    localparam int CFG_MODE_LO  = 1;
    localparam int WIN_NEG_LO   = 2;
    localparam int WIN_POS_LO   = 0;
    localparam logic [2:0] SINCE_SAT = 3'h4;

    // axi response codes
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // capture modes and controller states
    typedef enum logic [1:0] {
        MODE_OFF   = 2'b00,
        MODE_CONT  = 2'b01,
        MODE_NSHOT = 2'b10
    } mode_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CONT = 3'b001,
        ST_SKIP = 3'b010,
        ST_SHOT = 3'b011,
        ST_DONE = 3'b100
    } state_e;

endpackage : sysref_pkg

// ===== inc/sysref_cfg_if.sv
// configuration and status carrier between register file and core
// assumes both ends run on the same aclk
`timescale 1ns/100ps
interface sysref_cfg_if;
    logic       flag_rst;
    logic       trans_sel;
    logic       edge_sel;
    logic [1:0] mode;
    logic [3:0] ign_cnt;
    logic [1:0] win_neg;
    logic [1:0] win_pos;
    logic       arm;
    logic [7:0] status;

    modport regs (output flag_rst, trans_sel, edge_sel, mode, ign_cnt,
                  output win_neg, win_pos, arm, input status);
    modport core (input flag_rst, trans_sel, edge_sel, mode, ign_cnt,
                  input win_neg, win_pos, arm, output status);
endinterface : sysref_cfg_if

// ===== hdl/sysref_edge_detect.sv
// samples sysref on the chosen edge of the sample clock input
// assumes clk_in and sysref_in are synchronous to aclk
`timescale 1ns/100ps
module sysref_edge_detect
    import sysref_pkg::*;
(
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // pins
    input  wire logic clk_in,
    input  wire logic sysref_in,
    input  wire logic align_in,
    // selects
    input  wire logic edge_sel,
    input  wire logic trans_sel,
    // events
    output logic      tick,
    output logic      trans_ev,
    output logic      align_ev
);
    typedef struct packed {
        logic clk;
        logic ref_lvl;
        logic tick;
        logic trans;
        logic algn;
    } edge_s;

    edge_s s_q;
    edge_s s_d;
    logic  smp;

    always_comb begin
        s_d       = s_q;
        s_d.clk   = clk_in;
        smp       = edge_sel ? (s_q.clk & ~clk_in) : (~s_q.clk & clk_in);
        s_d.tick  = smp;
        s_d.algn  = smp & align_in;
        s_d.trans = 1'b0;
        if (smp) begin
            s_d.ref_lvl = sysref_in;
            s_d.trans = trans_sel ? (s_q.ref_lvl & ~sysref_in)
                                  : (~s_q.ref_lvl & sysref_in);
        end
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick     = s_q.tick;
    assign trans_ev = s_q.trans;
    assign align_ev = s_q.algn;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    tick_edge_a: assert property (
        tick |-> ($past(edge_sel) ? ($past(s_q.clk) && !$past(clk_in))
                                  : (!$past(s_q.clk) && $past(clk_in))))
        else $error("sample tick on wrong clock edge");

    trans_pol_a: assert property (
        trans_ev |-> ($past(trans_sel) ? !s_q.ref_lvl : s_q.ref_lvl))
        else $error("transition of wrong polarity accepted");
endmodule : sysref_edge_detect

// ===== hdl/sysref_axil_regs.sv
// axi4-lite slave holding the sysref control registers
// assumes one write and one read under way at most
`timescale 1ns/100ps
module sysref_axil_regs
    import sysref_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // write address and data
    input  wire logic [15:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // read
    input  wire logic [15:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // to core
    sysref_cfg_if.regs       cfg
);
    typedef struct packed {
        logic [7:0]  cfg;
        logic [7:0]  ign;
        logic [7:0]  win;
        logic        aw_ok;
        logic [15:0] awa;
        logic        w_ok;
        logic [7:0]  wd;
        logic        wst;
        logic        bv;
        logic [1:0]  br;
        logic        rv;
        logic [7:0]  rd;
        logic [1:0]  rr;
        logic        arm;
    } regs_s;

    regs_s s_q;
    regs_s s_d;

    // true when the address names a register
    function automatic logic mapped(input logic [15:0] a);
        return (a == ADDR_CFG) || (a == ADDR_IGN) ||
               (a == ADDR_WIN) || (a == ADDR_STAT);
    endfunction : mapped

    // channel capture, register write and read decode
    always_comb begin
        s_d     = s_q;
        s_d.arm = 1'b0;
        if (s_axi_awvalid && !s_q.aw_ok) begin
            s_d.aw_ok = 1'b1;
            s_d.awa   = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_q.w_ok) begin
            s_d.w_ok = 1'b1;
            s_d.wd   = s_axi_wdata[7:0];
            s_d.wst  = s_axi_wstrb[0];
        end
        if (s_q.bv && s_axi_bready) begin
            s_d.bv = 1'b0;
        end
        if (s_q.aw_ok && s_q.w_ok && !s_q.bv) begin
            s_d.aw_ok = 1'b0;
            s_d.w_ok  = 1'b0;
            s_d.bv    = 1'b1;
            s_d.br    = mapped(s_q.awa) ? RESP_OKAY : RESP_SLVERR;
            if (s_q.wst) begin
                if (s_q.awa == ADDR_CFG) begin
                    s_d.cfg = s_q.wd & CFG_WMASK;
                    s_d.arm = 1'b1;
                end else if (s_q.awa == ADDR_IGN) begin
                    s_d.ign = s_q.wd & IGN_WMASK;
                end else if (s_q.awa == ADDR_WIN) begin
                    s_d.win = s_q.wd & WIN_WMASK;
                end
            end
        end
        if (s_q.rv && s_axi_rready) begin
            s_d.rv = 1'b0;
        end
        if (s_axi_arvalid && !s_q.rv) begin
            s_d.rv = 1'b1;
            s_d.rr = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            if (s_axi_araddr == ADDR_CFG) begin
                s_d.rd = s_q.cfg;
            end else if (s_axi_araddr == ADDR_IGN) begin
                s_d.rd = s_q.ign;
            end else if (s_axi_araddr == ADDR_WIN) begin
                s_d.rd = s_q.win;
            end else if (s_axi_araddr == ADDR_STAT) begin
                s_d.rd = cfg.status;
            end else begin
                s_d.rd = 8'h00;
            end
        end
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q     <= '0;
            s_q.cfg <= CFG_RST;
            s_q.ign <= IGN_RST;
            s_q.win <= WIN_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // bus outputs
    assign s_axi_awready = !s_q.aw_ok;
    assign s_axi_wready  = !s_q.w_ok;
    assign s_axi_bvalid  = s_q.bv;
    assign s_axi_bresp   = s_q.br;
    assign s_axi_arready = !s_q.rv;
    assign s_axi_rvalid  = s_q.rv;
    assign s_axi_rresp   = s_q.rr;
    assign s_axi_rdata   = {24'h00_0000, s_q.rd};

    // fields toward the core
    assign cfg.flag_rst  = s_q.cfg[CFG_FLAG_RST];
    assign cfg.trans_sel = s_q.cfg[CFG_TRANS];
    assign cfg.edge_sel  = s_q.cfg[CFG_EDGE];
    assign cfg.mode      = s_q.cfg[CFG_MODE_LO +: 2];
    assign cfg.ign_cnt   = s_q.ign[3:0];
    assign cfg.win_neg   = s_q.win[WIN_NEG_LO +: 2];
    assign cfg.win_pos   = s_q.win[WIN_POS_LO +: 2];
    assign cfg.arm       = s_q.arm;
endmodule : sysref_axil_regs

// ===== hdl/sysref_capture_ctrl.sv
// top of the sysref capture control: mode controller and skew windows
// assumes sample clock, sysref and align pins synchronous to aclk
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
module sysref_capture_ctrl
    import sysref_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write
    input  wire logic [15:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [15:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // sysref pins
    input  wire logic        clk_in,
    input  wire logic        sysref_in,
    input  wire logic        align_in,
    // results
    output logic             sysref_capture,
    output logic             setup_err,
    output logic             hold_err
);
    // ---------------------------------------------------------------
    // submodules
    // ---------------------------------------------------------------
    sysref_cfg_if cfg ();

    logic tick;
    logic trans_ev;
    logic align_ev;

    // register file on the bus
    sysref_axil_regs u_regs (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .cfg           (cfg)
    );

    sysref_edge_detect u_edge (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .clk_in    (clk_in),
        .sysref_in (sysref_in),
        .align_in  (align_in),
        .edge_sel  (cfg.edge_sel),
        .trans_sel (cfg.trans_sel),
        .tick      (tick),
        .trans_ev  (trans_ev),
        .align_ev  (align_ev)
    );

    // ---------------------------------------------------------------
    // controller state
    // ---------------------------------------------------------------
    typedef struct packed {
        state_e     st;
        logic [3:0] skip;
        logic       pend;
        logic [1:0] pcnt;
        logic [2:0] since;
        logic       cap;
        logic       serr;
        logic       herr;
        logic [3:0] ncap;
    } core_s;

    core_s s_q;
    core_s s_d;
    logic  gate;
    logic  ok;
    logic  serr_ev;
    logic  herr_ev;

    // skew windows, mode sequencing and error flags
    always_comb begin
        s_d     = s_q;
        s_d.cap = 1'b0;
        ok      = 1'b0;
        serr_ev = 1'b0;
        herr_ev = 1'b0;
        gate    = (s_q.st == ST_CONT) || (s_q.st == ST_SHOT);
        if (tick) begin
            s_d.since = align_ev ? 3'h0 :
                        (s_q.since == SINCE_SAT) ? SINCE_SAT :
                        s_q.since + 3'h1;
            if (s_q.pend) begin
                if (align_ev) begin
                    ok       = 1'b1;
                    s_d.pend = 1'b0;
                end else if ((s_q.pcnt + 2'h1) == cfg.win_neg) begin
                    serr_ev  = 1'b1;
                    s_d.pend = 1'b0;
                end else begin
                    s_d.pcnt = s_q.pcnt + 2'h1;
                end
            end else if (trans_ev && gate) begin
                if (align_ev) begin
                    ok = 1'b1;
                end else if ((s_q.since + 3'h1) <= {1'b0, cfg.win_pos}) begin
                    ok = 1'b1;
                end else if (cfg.win_neg != 2'b00) begin
                    s_d.pend = 1'b1;
                    s_d.pcnt = 2'h0;
                end else begin
                    herr_ev = 1'b1;
                end
            end
        end
        case (s_q.st)
            ST_CONT: begin
                if (ok) begin
                    s_d.cap = 1'b1;
                end
            end
            ST_SKIP: begin
                if (tick && trans_ev) begin
                    s_d.skip = s_q.skip - 4'h1;
                    if (s_q.skip == 4'h1) begin
                        s_d.st = ST_SHOT;
                    end
                end
            end
            ST_SHOT: begin
                if (ok) begin
                    s_d.cap = 1'b1;
                    s_d.st  = ST_DONE;
                end
            end
            default: begin
            end
        endcase
        if (cfg.mode == MODE_CONT) begin
            if (s_q.st != ST_CONT) begin
                s_d.st   = ST_CONT;
                s_d.pend = 1'b0;
            end
        end else if (cfg.mode == MODE_NSHOT) begin
            if (cfg.arm) begin
                s_d.st   = (cfg.ign_cnt == 4'h0) ? ST_SHOT : ST_SKIP;
                s_d.skip = cfg.ign_cnt;
                s_d.pend = 1'b0;
            end
        end else begin
            s_d.st   = ST_IDLE;
            s_d.pend = 1'b0;
            s_d.cap  = 1'b0;
        end
        if (s_d.cap) begin
            s_d.ncap = s_q.ncap + 4'h1;
        end
        if (serr_ev) begin
            s_d.serr = 1'b1;
        end
        if (herr_ev) begin
            s_d.herr = 1'b1;
        end
        if (cfg.flag_rst) begin
            s_d.serr = 1'b0;
            s_d.herr = 1'b0;
        end
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q       <= '0;
            s_q.st    <= ST_IDLE;
            s_q.since <= SINCE_SAT;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs and status byte
    assign sysref_capture = s_q.cap;
    assign setup_err      = s_q.serr;
    assign hold_err       = s_q.herr;
    assign cfg.status     = {s_q.ncap, 1'b0, s_q.pend,
                             s_q.st == ST_DONE,
                             (s_q.st == ST_SKIP) || (s_q.st == ST_SHOT)};

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    logic [4:0] ntr_q;
    logic [1:0] narm_q;

    // transitions and captures since the last arm
    always_ff @(posedge aclk) begin
        if (!aresetn || cfg.arm) begin
            ntr_q  <= 5'h00;
            narm_q <= 2'h0;
        end else begin
            if (tick && trans_ev && ntr_q != 5'h1F) begin
                ntr_q <= ntr_q + 5'h01;
            end
            if (s_d.cap && narm_q != 2'h3) begin
                narm_q <= narm_q + 2'h1;
            end
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    flag_clear_a: assert property (
        cfg.flag_rst |=> !setup_err && !hold_err)
        else $error("error flag set while flag reset is on");

    mode_off_a: assert property (
        (cfg.mode != MODE_CONT && cfg.mode != MODE_NSHOT)
        |=> !sysref_capture && s_q.st == ST_IDLE)
        else $error("capture while mode disabled");

    cont_exact_a: assert property (
        (s_q.st == ST_CONT && cfg.mode == MODE_CONT && !s_q.pend
         && tick && trans_ev && align_ev) |=> sysref_capture)
        else $error("aligned transition not captured");

    skip_count_a: assert property (
        (sysref_capture && s_q.st == ST_DONE) |-> ntr_q > {1'b0, cfg.ign_cnt})
        else $error("n-shot captured too early");

    one_shot_a: assert property (
        (s_q.st == ST_DONE) |-> narm_q == 2'h1)
        else $error("n-shot captured more than once");

    neg_zero_a: assert property (
        (cfg.win_neg == 2'b00 && !s_q.pend) |=> !s_q.pend)
        else $error("pending with zero negative window");

    neg_bound_a: assert property (
        s_q.pend |-> s_q.pcnt < cfg.win_neg)
        else $error("negative skew wait beyond window");

    pos_exact_a: assert property (
        (s_q.st == ST_CONT && cfg.mode == MODE_CONT && !s_q.pend && tick
         && trans_ev && !align_ev && cfg.win_pos == 2'b00) |=> !sysref_capture)
        else $error("late transition captured with zero window");

    // main scenarios
    cont_cap_c: cover property (s_q.st == ST_CONT && sysref_capture);
    nshot_cap_c: cover property (
        sysref_capture && s_q.st == ST_DONE && cfg.ign_cnt != 4'h0);
    setup_err_c: cover property ($rose(setup_err));
    hold_err_c: cover property ($rose(hold_err));
endmodule : sysref_capture_ctrl

// ===== tb/sysref_src_model.sv
// model of the external source of sample clock, sysref and align
// assumes aclk at least eight times faster than the sample clock
`timescale 1ns/100ps
module sysref_src_model (
    // clocking
    input  wire logic aclk,
    // requested levels
    input  wire logic want_sr,
    input  wire logic want_al,
    // pins
    output logic      clk_in    = 1'b0,
    output logic      sysref_in = 1'b0,
    output logic      align_in  = 1'b0
);
    logic [1:0] div_q = 2'h0;

    // free running clock, levels move only as it falls
    always @(posedge aclk) begin
        div_q <= div_q + 2'h1;
        if (div_q == 2'h3) begin
            clk_in <= ~clk_in;
            if (clk_in) begin
                sysref_in <= want_sr;
                align_in  <= want_al;
            end
        end
    end
endmodule : sysref_src_model

// ===== tb/sysref_capture_ctrl_tb_top.sv
// self-checking bench of the sysref capture control
// assumes the source model drives the sysref pins
`timescale 1ns/100ps
module sysref_capture_ctrl_tb_top;
    import sysref_pkg::*;
    logic        aclk    = 1'b0;
    logic        aresetn = 1'b0;
    logic [15:0] awaddr  = 16'h0000;
    logic [15:0] araddr  = 16'h0000;
    logic [31:0] wdata   = 32'h0000_0000;
    logic        awvalid = 1'b0;
    logic        wvalid  = 1'b0;
    logic        bready  = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready  = 1'b0;
    logic        want_sr = 1'b0;
    logic        want_al = 1'b1;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic        clk_in, sysref_in, align_in, cap, s_err, h_err;
    logic [1:0]  bq[$];
    logic [33:0] rq[$];
    logic        cq[$];
    logic [15:0] adr[3] = '{ADDR_CFG, ADDR_IGN, ADDR_WIN};
    logic [7:0]  msk[3] = '{CFG_WMASK, IGN_WMASK, WIN_WMASK};
    logic [3:0]  n;
    logic [3:0]  wstrb   = 4'hF;
    int          errors = 0;
    int          checks_done = 0;
    int          cycles = 0;

    always #2.5 aclk = ~aclk;

    sysref_capture_ctrl DUT (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .clk_in(clk_in), .sysref_in(sysref_in), .align_in(align_in),
        .sysref_capture(cap), .setup_err(s_err), .hold_err(h_err));

    sysref_src_model SRC (.aclk(aclk), .want_sr(want_sr),
        .want_al(want_al), .clk_in(clk_in), .sysref_in(sysref_in),
        .align_in(align_in));

    task automatic cmp(input string what, input logic [33:0] e,
                       input logic [33:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s exp %h got %h", what, e, g);
        end
    endtask : cmp

    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up

    task automatic wr(input logic [15:0] a, input logic [7:0] d,
                      input logic [1:0] r);
        logic ah, wh, bh;
        bh = 1'b0;
        @(posedge aclk);
        bq.push_back(r);
        awaddr  <= a;
        wdata   <= {24'($urandom), d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!bh) begin
            @(negedge aclk);
            ah = awready & awvalid;
            wh = wready & wvalid;
            bh = bvalid;
            @(posedge aclk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [33:0] e);
        logic ah, h;
        h = 1'b0;
        @(posedge aclk);
        rq.push_back(e);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!h) begin
            @(negedge aclk);
            ah = arready & arvalid;
            h  = rvalid;
            @(posedge aclk);
            if (ah) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask : rd

    // one sysref pulse gives one rising and one falling transition
    task automatic pulse(input int k);
        repeat (k) begin
            want_sr <= 1'b1;
            repeat (16) @(posedge aclk);
            want_sr <= 1'b0;
            repeat (16) @(posedge aclk);
        end
    endtask : pulse

    // one sysref and align level per sample clock, bit 16 first
    task automatic play(input logic [19:0] sr, input logic [19:0] al);
        for (int t = 16; t >= 0; t--) begin
            want_sr <= sr[t];
            want_al <= al[t];
            repeat (8) @(posedge aclk);
        end
    endtask : play

    // takes the oldest note whenever a result shows at the outputs
    always @(negedge aclk) begin
        if (bvalid && bready)
            cmp("bresp", bq.size() ? bq.pop_front() : 2'bx, bresp);
        if (rvalid && rready)
            cmp("rdata", rq.size() ? rq.pop_front() : 34'bx, {rresp, rdata});
        if (cap === 1'b1)
            cmp("capture", cq.size() ? cq.pop_front() : 1'bx,
                clk_in);
    end

    // hang guard
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            wrap_up();
        end
    end

    // main sequence
    initial begin
        void'($urandom(32'h4403));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (adr[i]) begin
            rd(adr[i], 34'h0);
            wr(adr[i], 8'hFF, RESP_OKAY);
            rd(adr[i], {26'h0, msk[i]});
            wr(adr[i], 8'h00, RESP_OKAY);
        end
        // byte lane zero off leaves the register alone
        wstrb <= 4'hE;
        wr(ADDR_IGN, 8'h05, RESP_OKAY);
        wstrb <= 4'hF;
        rd(ADDR_IGN, 34'h0);
        wr(16'h0490, 8'h5A, RESP_SLVERR);
        rd(16'h0490, {RESP_SLVERR, 32'h0});
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_CFG, 8'(c << 3), RESP_OKAY);
            wr(ADDR_CFG, 8'((c << 3) | 2), RESP_OKAY);
            cq.push_back(~c[0]);
            cq.push_back(~c[0]);
            pulse(2);
            wr(ADDR_CFG, 8'(c << 3), RESP_OKAY);
        end
        for (int m = 0; m < 7; m += 6) begin
            wr(ADDR_CFG, 8'(m), RESP_OKAY);
            pulse(1);
        end
        for (int i = 0; i < 3; i++) begin
            n = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($urandom);
            wr(ADDR_IGN, {4'h0, n}, RESP_OKAY);
            cq.push_back(1'b1);
            wr(ADDR_CFG, 8'h04, RESP_OKAY);
            pulse(int'(n) + 3);
        end
        rd(ADDR_STAT, 34'h0_0000_00B2);
        wr(ADDR_CFG, 8'h02, RESP_OKAY);
        want_al <= 1'b0;
        pulse(1);
        cmp("hold_err", 34'h1, 34'(h_err));
        cmp("setup_err", 34'h0, 34'(s_err));
        wr(ADDR_CFG, 8'h42, RESP_OKAY);
        pulse(1);
        cmp("hold_err", 34'h0, 34'(h_err));
        // late by one accepted, early by three accepted, then missed
        wr(ADDR_WIN, 8'h0D, RESP_OKAY);
        wr(ADDR_CFG, 8'h02, RESP_OKAY);
        cq.push_back(1'b1);
        cq.push_back(1'b1);
        play(20'h0_8F1E, 20'h1_2140);
        cmp("setup_err", 34'h1, 34'(s_err));
        cmp("hold_err", 34'h0, 34'(h_err));
        rd(ADDR_STAT, 34'h0_0000_00D0);
        cmp("cap_left", 34'h0, 34'(cq.size()));
        wrap_up();
    end
endmodule : sysref_capture_ctrl_tb_top
